// >>> core/pvic_defines.vh
// register offsets, field positions, reset values and codes of the interrupt controller
`ifndef PVIC_DEFINES_VH
`define PVIC_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PVIC_OFS_ENABLE_A  8'h00
`define PVIC_OFS_ENABLE_B  8'h04
`define PVIC_OFS_PENDING_A 8'h08
`define PVIC_OFS_PENDING_B 8'h0c
`define PVIC_OFS_MASK_A    8'h10
`define PVIC_OFS_MASK_B    8'h14
`define PVIC_OFS_SERVICE_A 8'h18
`define PVIC_OFS_SERVICE_B 8'h1c
`define PVIC_OFS_VECTOR    8'h20
`define PVIC_OFS_STATUS    8'h24

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PVIC_VEC_SW_EOI    3
`define PVIC_VEC_BASE_HI   7
`define PVIC_VEC_BASE_LO   4
`define PVIC_VEC_RESET     8'h00
`define PVIC_BANK_RESET    8'h00
`define PVIC_NUM_CH        16
`define PVIC_RESP_OKAY     2'h0
`define PVIC_RESP_SLVERR   2'h2

`endif

// >>> core/pvic_top.v
// sixteen-channel prioritized vectored interrupt controller with axi4-lite registers
// How it works
// RL1: sixteen channels ranked by 4-bit code, 1111 highest, 0000 lowest.
// RL2: channel code forms low four vector bits, one fixed code per source.
// RL3: enable banks set by one, cleared by zero, and readable.
// RL4: disabled channel ignores events; disabling clears its pending bit.
// RL5: disabling leaves in-service bit alone until cleared normally.
// RL6: event on enabled channel sets its pending bit.
// RL7: acknowledged channel outputs its vector and its pending bit clears.
// RL8: pending banks are readable for polling.
// RL9: zero written to pending bit clears it; one written has no effect.
// RL10: mask zero blocks request, but pending still latches.
// RL11: clearing mask ends that request; irq drops if nothing else requests.
// RL12: re-setting mask resumes request unless higher priority blocks; masks readable.
// RL13: vector base bit selects eoi mode; automatic mode holds in-service bits reset.
// RL14: automatic mode: passing vector clears pending and nothing else is kept.
// RL15: software mode: passing vector sets in-service and clears pending.
// RL16: in-service channel blocks lower channels from request and acknowledge.
// RL17: repeat event on in-service channel latches pending but waits to request.
// RL18: in-service readable; zero clears, one leaves, software cannot set.
// RL19: vector is base bits 7..4 above channel code bits 3..0.
// RL20: acknowledge needs int_ack_n low, chain_in low, and an acknowledgeable channel.
// RL21: every part in a chain shares one int_ack_n.
// RL22: on int_ack_n fall freeze, prioritize, pass chain; winner vectors, holds chain_out.
// RL23: irq_out_n low when any channel is enabled, pending, unmasked and unblocked.
`timescale 1ns/100ps
`include "pvic_defines.vh"

module pvic_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] irq_event,
	input  wire        int_ack_n,
	input  wire        chain_in,
	output reg         irq_out_n,
	output reg         chain_out,
	output reg         transfer_ack_n,
	output reg  [7:0]  vec_out,
	output reg         vec_oe
);

// ----------------------------------------
// functions
// ----------------------------------------
// highest set bit index and a found flag, bit 15 is code 1111
function [4:0] top_bit;
	input [15:0] v;
	integer      i;
	begin
		top_bit = 5'h00;
		for (i = 0; i < 16; i = i + 1) begin
			if (v[i]) begin
				top_bit = {1'b1, i[3:0]};
			end
		end
	end
endfunction

// every channel at or below the highest in-service channel is blocked
function [15:0] blocked_by;
	input [15:0] svc;
	integer      i;
	reg          hit;
	begin
		hit        = 1'b0;
		blocked_by = 16'h0000;
		for (i = 15; i >= 0; i = i - 1) begin
			hit           = hit | svc[i];
			blocked_by[i] = hit;
		end
	end
endfunction

// ----------------------------------------
// acknowledge sequencer states
// ----------------------------------------
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ARB  = 2'h1;
localparam [1:0] ST_HOLD = 2'h2;
localparam [1:0] ST_DONE = 2'h3;

// ----------------------------------------
// state
// ----------------------------------------
reg [15:0] enable_ff;
reg [15:0] pending_ff;
reg [15:0] mask_ff;
reg [15:0] service_ff;
reg [7:0]  vector_base_ff;
reg [15:0] nxt_enable;
reg [15:0] nxt_pending;
reg [15:0] nxt_mask;
reg [15:0] nxt_service;
reg [7:0]  nxt_vector_base;

reg [15:0] evt_meta_ff;
reg [15:0] evt_sync_ff;
reg [15:0] evt_prev_ff;
reg [1:0]  ack_meta_ff;
reg [1:0]  ack_sync_ff;

reg [1:0]  ack_state_ff;
reg [4:0]  win_ff;
reg [1:0]  nxt_ack_state;
reg [4:0]  nxt_win;

reg [31:0] aw_addr_ff;
reg        aw_have_ff;
reg [31:0] w_data_ff;
reg [3:0]  w_strb_ff;
reg        w_have_ff;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// events are rising edges taken after two flops
// both link pins share one flop pair so they are judged on the same edge
always @(posedge aclk) begin
	if (!aresetn) begin
		evt_meta_ff <= 16'h0000;
		evt_sync_ff <= 16'h0000;
		evt_prev_ff <= 16'h0000;
		ack_meta_ff <= 2'h3;
		ack_sync_ff <= 2'h3;
	end else begin
		evt_meta_ff <= irq_event;
		evt_sync_ff <= evt_meta_ff;
		evt_prev_ff <= evt_sync_ff;
		ack_meta_ff <= {chain_in, int_ack_n};
		ack_sync_ff <= ack_meta_ff;
	end
end

wire [15:0] evt_edge = evt_sync_ff & ~evt_prev_ff;
wire        ack_low  = ~ack_sync_ff[0];
wire        chain_lo = ~ack_sync_ff[1];
wire        sw_eoi   = vector_base_ff[`PVIC_VEC_SW_EOI];
// software may clear the frozen winner before the chain arrives; then it must not answer
wire        win_live = win_ff[4] && pending_ff[win_ff[3:0]]; // RL20

// ----------------------------------------
// priority
// ----------------------------------------
wire [15:0] blk       = sw_eoi ? blocked_by(service_ff) : 16'h0000; // RL16
wire [15:0] ackable   = enable_ff & pending_ff & mask_ff & ~blk; // RL10 RL16 RL17
wire [4:0]  best      = top_bit(ackable); // RL1
wire        any_req   = |ackable; // RL11 RL12 RL23

// ----------------------------------------
// axi4-lite write path
// ----------------------------------------
wire        wr_go  = aw_have_ff && w_have_ff && !s_axi_bvalid;
wire [7:0]  wr_ofs = aw_addr_ff[7:0];
wire        wr_hit = (aw_addr_ff[31:8] == 24'h000000) && (wr_ofs <= `PVIC_OFS_STATUS) &&
	(wr_ofs[1:0] == 2'h0);
wire        wr_b0  = wr_go && w_strb_ff[0];

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_addr_ff    <= 32'h00000000;
		aw_have_ff    <= 1'b0;
		w_data_ff     <= 32'h00000000;
		w_strb_ff     <= 4'h0;
		w_have_ff     <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= `PVIC_RESP_OKAY;
	end else begin
		s_axi_awready <= !aw_have_ff && !s_axi_awready;
		s_axi_wready  <= !w_have_ff && !s_axi_wready;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_ff    <= s_axi_awaddr;
			aw_have_ff    <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data_ff    <= s_axi_wdata;
			w_strb_ff    <= s_axi_wstrb;
			w_have_ff    <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (wr_go) begin
			aw_have_ff   <= 1'b0;
			w_have_ff    <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `PVIC_RESP_OKAY : `PVIC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------
// channel registers
// ----------------------------------------
// events and vector passing act after software writes, so a new event beats a clear
always @* begin
	nxt_enable      = enable_ff;
	nxt_pending     = pending_ff;
	nxt_mask        = mask_ff;
	nxt_service     = service_ff;
	nxt_vector_base = vector_base_ff;
	if (wr_b0 && wr_hit) begin
		case (wr_ofs)
			`PVIC_OFS_ENABLE_A:  nxt_enable[7:0]   = w_data_ff[7:0]; // RL3 RL5
			`PVIC_OFS_ENABLE_B:  nxt_enable[15:8]  = w_data_ff[7:0]; // RL3 RL5
			`PVIC_OFS_PENDING_A: nxt_pending[7:0]  = pending_ff[7:0] & w_data_ff[7:0]; // RL9
			`PVIC_OFS_PENDING_B: nxt_pending[15:8] = pending_ff[15:8] & w_data_ff[7:0]; // RL9
			`PVIC_OFS_MASK_A:    nxt_mask[7:0]     = w_data_ff[7:0]; // RL10 RL11 RL12
			`PVIC_OFS_MASK_B:    nxt_mask[15:8]    = w_data_ff[7:0]; // RL10 RL11 RL12
			`PVIC_OFS_SERVICE_A: nxt_service[7:0]  = service_ff[7:0] & w_data_ff[7:0]; // RL18
			`PVIC_OFS_SERVICE_B: nxt_service[15:8] = service_ff[15:8] & w_data_ff[7:0]; // RL18
			`PVIC_OFS_VECTOR:    nxt_vector_base   = {w_data_ff[7:3], 3'h0}; // RL13 RL19
			default:             nxt_vector_base   = vector_base_ff;
		endcase
	end
	// vector passed on the frozen winner
	if (ack_state_ff == ST_ARB && win_live) begin
		nxt_pending[win_ff[3:0]] = 1'b0; // RL7 RL14 RL15
		if (sw_eoi) begin
			nxt_service[win_ff[3:0]] = 1'b1; // RL15
		end
	end
	nxt_pending = nxt_pending | (evt_edge & nxt_enable); // RL6 RL10 RL17
	nxt_pending = nxt_pending & nxt_enable; // RL4
	if (!nxt_vector_base[`PVIC_VEC_SW_EOI]) begin
		nxt_service = 16'h0000; // RL13 RL14
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		enable_ff      <= {2{`PVIC_BANK_RESET}};
		pending_ff     <= {2{`PVIC_BANK_RESET}};
		mask_ff        <= {2{`PVIC_BANK_RESET}};
		service_ff     <= {2{`PVIC_BANK_RESET}};
		vector_base_ff <= `PVIC_VEC_RESET;
	end else begin
		enable_ff      <= nxt_enable;
		pending_ff     <= nxt_pending;
		mask_ff        <= nxt_mask;
		service_ff     <= nxt_service;
		vector_base_ff <= nxt_vector_base;
	end
end

// ----------------------------------------
// acknowledge sequencer
// ----------------------------------------
// one cycle freezes the winner so every chained part decides on the same snapshot
always @* begin
	nxt_ack_state = ack_state_ff;
	nxt_win       = win_ff;
	case (ack_state_ff)
		ST_IDLE: begin
			if (ack_low) begin
				nxt_win       = best; // RL22
				nxt_ack_state = ST_HOLD;
			end
		end
		ST_HOLD: begin
			if (!ack_low) begin
				nxt_ack_state = ST_IDLE;
			end else if (chain_lo) begin
				nxt_ack_state = ST_ARB; // RL20
			end
		end
		ST_ARB: begin
			nxt_ack_state = ST_DONE;
		end
		ST_DONE: begin
			if (!ack_low) begin
				nxt_ack_state = ST_IDLE; // RL22
			end
		end
		default: nxt_ack_state = ST_IDLE;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		ack_state_ff   <= ST_IDLE;
		win_ff         <= 5'h00;
		irq_out_n      <= 1'b1;
		chain_out      <= 1'b1;
		transfer_ack_n <= 1'b1;
		vec_out        <= 8'h00;
		vec_oe         <= 1'b0;
	end else begin
		ack_state_ff <= nxt_ack_state;
		win_ff       <= nxt_win;
		irq_out_n    <= ~any_req; // RL23
		if (ack_state_ff == ST_ARB) begin
			if (win_live) begin
				vec_out        <= {vector_base_ff[`PVIC_VEC_BASE_HI:`PVIC_VEC_BASE_LO],
					win_ff[3:0]}; // RL2 RL19
				vec_oe         <= 1'b1;
				transfer_ack_n <= 1'b0; // RL22
				chain_out      <= 1'b1;
			end else begin
				chain_out <= 1'b0; // RL22
			end
		end else if (nxt_ack_state == ST_IDLE) begin
			vec_oe         <= 1'b0;
			transfer_ack_n <= 1'b1;
			chain_out      <= 1'b1;
		end
	end
end

// ----------------------------------------
// axi4-lite read path
// ----------------------------------------
reg  [7:0] rd_byte;
wire [7:0] rd_ofs = s_axi_araddr[7:0];
wire       rd_hit = (s_axi_araddr[31:8] == 24'h000000) && (rd_ofs <= `PVIC_OFS_STATUS) &&
	(rd_ofs[1:0] == 2'h0);

always @* begin
	case (rd_ofs)
		`PVIC_OFS_ENABLE_A:  rd_byte = enable_ff[7:0]; // RL3
		`PVIC_OFS_ENABLE_B:  rd_byte = enable_ff[15:8];
		`PVIC_OFS_PENDING_A: rd_byte = pending_ff[7:0]; // RL8
		`PVIC_OFS_PENDING_B: rd_byte = pending_ff[15:8];
		`PVIC_OFS_MASK_A:    rd_byte = mask_ff[7:0]; // RL12
		`PVIC_OFS_MASK_B:    rd_byte = mask_ff[15:8];
		`PVIC_OFS_SERVICE_A: rd_byte = service_ff[7:0]; // RL18
		`PVIC_OFS_SERVICE_B: rd_byte = service_ff[15:8];
		`PVIC_OFS_VECTOR:    rd_byte = vector_base_ff;
		`PVIC_OFS_STATUS:    rd_byte = {2'h0, any_req, best};
		default:             rd_byte = 8'h00;
	endcase
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h00000000;
		s_axi_rresp   <= `PVIC_RESP_OKAY;
	end else begin
		s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_hit ? rd_byte : 8'h00};
			s_axi_rresp   <= rd_hit ? `PVIC_RESP_OKAY : `PVIC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

endmodule

// >>> tb/pvic_host_model.sv
// host processor stand-in for the acknowledge link, first in its chain
`timescale 1ns/100ps
module pvic_host_model (
	input  wire       aclk,
	input  wire       transfer_ack_n,
	input  wire       chain_out,
	input  wire [7:0] vec_out,
	output logic      int_ack_n,
	output logic      chain_in
);
	initial begin
		int_ack_n = 1'b1;
		chain_in = 1'b0;
	end
	// slow keeps the acknowledge low past the answer
	task automatic ack(input int slow, output logic [7:0] v, output logic hit);
		int n;
		n = 0;
		@(posedge aclk);
		int_ack_n <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (transfer_ack_n && chain_out && n < 30);
		hit = !transfer_ack_n;
		v = vec_out;
		repeat (slow) @(posedge aclk);
		int_ack_n <= 1'b1;
		repeat (6) @(posedge aclk);
	endtask
endmodule

// >>> tb/pvic_props.sv
// port-level property checker for the interrupt controller
`timescale 1ns/100ps
module pvic_props (
	input wire        aclk,
	input wire        aresetn,
	input wire        int_ack_n,
	input wire        chain_in,
	input wire        transfer_ack_n,
	input wire        chain_out,
	input wire [7:0]  vec_out,
	input wire        vec_oe,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid
);
	// ----------------------------------------
	// acknowledge link and bus answers
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_ack_drives_vec: assert property (!transfer_ack_n |-> vec_oe && chain_out)
		else $error("vector owner without vector or with chain passed");
	chk_pass_down: assert property (!chain_out |-> transfer_ack_n && !vec_oe)
		else $error("chain passed while supplying a vector");
	chk_ack_cause: assert property ($fell(transfer_ack_n) |-> !$past(int_ack_n, 4) && !chain_in)
		else $error("vector supplied without a settled acknowledge");
	chk_idle_quiet: assert property (int_ack_n [*5] |=> transfer_ack_n && chain_out && !vec_oe)
		else $error("link outputs active while acknowledge idle");
	chk_vec_steady: assert property (!transfer_ack_n && !$past(transfer_ack_n) |-> $stable(vec_out))
		else $error("vector moved during acknowledge");
	chk_ack_bound: assert property ($fell(int_ack_n) && !chain_in |->
		##[1:12] (!transfer_ack_n || !chain_out || int_ack_n))
		else $error("acknowledge got no answer");
	chk_ack_holds: assert property (!transfer_ack_n && !int_ack_n |=> !transfer_ack_n)
		else $error("vector dropped while acknowledge held");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_write_answer: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
		else $error("write response dropped unaccepted");
endmodule

bind pvic_top pvic_props u_pvic_props (
	.aclk           (aclk),
	.aresetn        (aresetn),
	.int_ack_n      (int_ack_n),
	.chain_in       (chain_in),
	.transfer_ack_n (transfer_ack_n),
	.chain_out      (chain_out),
	.vec_out        (vec_out),
	.vec_oe         (vec_oe),
	.s_axi_bvalid   (s_axi_bvalid),
	.s_axi_bready   (s_axi_bready),
	.s_axi_arvalid  (s_axi_arvalid),
	.s_axi_arready  (s_axi_arready),
	.s_axi_rvalid   (s_axi_rvalid)
);

// >>> tb/tb_pvic_top.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`include "pvic_defines.vh"
module tb_pvic_top;
	localparam logic [31:0] a_en = `PVIC_OFS_ENABLE_A;
	localparam logic [31:0] b_en = `PVIC_OFS_ENABLE_B;
	localparam logic [31:0] a_pd = `PVIC_OFS_PENDING_A;
	localparam logic [31:0] b_pd = `PVIC_OFS_PENDING_B;
	localparam logic [31:0] a_mk = `PVIC_OFS_MASK_A;
	localparam logic [31:0] b_mk = `PVIC_OFS_MASK_B;
	localparam logic [31:0] a_sv = `PVIC_OFS_SERVICE_A;
	localparam logic [31:0] b_sv = `PVIC_OFS_SERVICE_B;
	localparam logic [31:0] a_vc = `PVIC_OFS_VECTOR;
	localparam logic [31:0] a_st = `PVIC_OFS_STATUS;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, hit;
	logic [15:0] irq_event = '0;
	logic [7:0]  v;
	logic [1:0]  r;
	wire         int_ack_n, chain_in, irq_out_n, chain_out, transfer_ack_n, vec_oe;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [7:0]  vec_out;
	wire  [31:0] rdata;
	wire  [1:0]  bresp, rresp;
	int          fail_count = 0, total_checks = 0;
	// events, winning vector, pending left after the acknowledge
	logic [39:0] rows [6] = '{{16'h8001, 8'haf, 16'h0001}, {16'h0003, 8'ha1, 16'h0001},
		{16'h2100, 8'had, 16'h0100}, {16'h0011, 8'ha4, 16'h0001},
		{16'h0600, 8'haa, 16'h0200}, {16'h00c0, 8'ha7, 16'h0040}};

	always #20 aclk = ~aclk;

	pvic_top u_pvic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_event(irq_event), .int_ack_n(int_ack_n), .chain_in(chain_in),
		.irq_out_n(irq_out_n), .chain_out(chain_out), .transfer_ack_n(transfer_ack_n),
		.vec_out(vec_out), .vec_oe(vec_oe));
	pvic_host_model u_pvic_host_model (.aclk(aclk), .transfer_ack_n(transfer_ack_n),
		.chain_out(chain_out), .vec_out(vec_out), .int_ack_n(int_ack_n), .chain_in(chain_in));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] x);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, x};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rc(input logic [31:0] a, input logic [7:0] e);
		rd(a);
		chk(d, {24'h0, e});
	endtask
	task automatic rp(input logic [15:0] e);
		rc(a_pd, e[7:0]);
		rc(b_pd, e[15:8]);
	endtask
	task automatic fire(input logic [15:0] ev);
		@(posedge aclk);
		irq_event <= ev;
		repeat (3) @(posedge aclk);
		irq_event <= 16'h0000;
		repeat (8) @(posedge aclk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rc(a_en, 8'h00);
		rc(a_vc, 8'h00);
		wr(a_en, 8'hff);
		wr(b_en, 8'hff);
		wr(a_mk, 8'hff);
		wr(b_mk, 8'hff);
		chk(r, 2'h0);
		wr(a_vc, 8'ha0);
		foreach (rows[i]) begin
			fire(rows[i][39:24]);
			chk(irq_out_n, 1'b0);
			rc(a_st, {4'h3, rows[i][19:16]});
			u_pvic_host_model.ack(i % 3, v, hit);
			chk(v, rows[i][23:16]);
			rp(rows[i][15:0]);
			wr(a_pd, 8'hff);
			rp(rows[i][15:0]);
			wr(a_pd, 8'h00);
			wr(b_pd, 8'h00);
			rp(16'h0000);
		end
		$display("priority rows done");
		u_pvic_host_model.ack(0, v, hit);
		chk(hit, 1'b0);
		wr(a_mk, 8'hf7);
		fire(16'h0008);
		rp(16'h0008);
		chk(irq_out_n, 1'b1);
		rc(a_mk, 8'hf7);
		wr(a_mk, 8'hff);
		repeat (2) @(posedge aclk);
		chk(irq_out_n, 1'b0);
		wr(a_mk, 8'hf7);
		repeat (2) @(posedge aclk);
		chk(irq_out_n, 1'b1);
		wr(a_mk, 8'hff);
		wr(a_en, 8'hf7);
		rp(16'h0000);
		fire(16'h0008);
		rp(16'h0000);
		rc(a_en, 8'hf7);
		wr(a_en, 8'hff);
		rd(32'h40);
		chk(r, 2'h2);
		chk(d, 32'h0);
		wr(32'h40, 8'h00);
		chk(r, 2'h2);
		$display("mask and enable done");
		wr(a_vc, 8'ha8);
		fire(16'h0010);
		u_pvic_host_model.ack(1, v, hit);
		chk(v, 8'ha4);
		rc(a_sv, 8'h10);
		fire(16'h0014);
		chk(irq_out_n, 1'b1);
		rp(16'h0014);
		u_pvic_host_model.ack(0, v, hit);
		chk(hit, 1'b0);
		fire(16'h0200);
		chk(irq_out_n, 1'b0);
		u_pvic_host_model.ack(0, v, hit);
		chk(v, 8'ha9);
		wr(a_sv, 8'hff);
		rc(a_sv, 8'h10);
		wr(b_sv, 8'h00);
		wr(a_sv, 8'hef);
		u_pvic_host_model.ack(0, v, hit);
		chk(v, 8'ha4);
		wr(a_en, 8'h00);
		rc(a_sv, 8'h10);
		rp(16'h0000);
		wr(a_en, 8'hff);
		wr(a_vc, 8'ha0);
		rc(a_sv, 8'h00);
		$display("service mode done");
		fire(16'h0001);
		chk(irq_out_n, 1'b0);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(irq_out_n, 1'b1);
		rp(16'h0000);
		rc(a_mk, 8'h00);
		rc(a_vc, 8'h00);
		$display("mid-run reset done");
		close_out();
	end

	// cut a hang short, far beyond the seven hundred or so cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		close_out();
	end
endmodule
